// *** cis_pkg.sv ***
package cis_pkg;
    // Register port and storage geometry
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int PCW = 13;
    localparam int FAW = 7;
    localparam int SPW = 3;
    localparam int STACK_DEPTH = 8;
    localparam int FILE_DEPTH = 128;

    // Register offsets
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_PC = 8'h03;
    localparam logic [7:0] REG_STACK = 8'h04;
    localparam logic [7:0] REG_WDOG = 8'h05;
    localparam logic [7:0] REG_FADDR = 8'h06;
    localparam logic [7:0] REG_FDATA = 8'h07;
    localparam logic [7:0] REG_WAKE = 8'h08;

    // Status register bit positions
    localparam int ST_C = 0;
    localparam int ST_NCARRY = 1;
    localparam int ST_Z = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_IRQEN = 5;
    localparam int ST_HALT = 6;
    localparam int ST_STALL = 7;

    // Values after reset, plus the prescaler terminal count
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic RST_TIMEOUT = 1'b1;
    localparam logic RST_PWRDN = 1'b1;
    localparam logic RST_IRQEN = 1'b0;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRESC_CLEAR = 8'h00;
    localparam logic [7:0] PRESC_MAX = 8'hFF;

    // Opcode field patterns of the 14-bit instruction word
    localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
    localparam logic [3:0] OPC_RET_LIT = 4'hD;
    localparam logic [4:0] OPC_SUB_LIT = 5'h1E;
    localparam logic [5:0] OPC_XOR_LIT = 6'h3A;
    localparam logic [5:0] OPC_ROT_L = 6'h0D;
    localparam logic [5:0] OPC_ROT_R = 6'h0C;
    localparam logic [5:0] OPC_SUB_FILE = 6'h02;
    localparam logic [5:0] OPC_SWAP = 6'h0E;
    localparam logic [5:0] OPC_XOR_FILE = 6'h06;
    localparam logic [6:0] OPC_STORE = 7'h01;
    localparam logic [13:0] OPC_RET_IRQ = 14'h0009;
    localparam logic [13:0] OPC_RET_SUB = 14'h0008;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_WAIT = 3'h2,
        ST_HALTED = 3'h4
    } cis_state_t;

    typedef enum logic [3:0] {
        OP_NOP, OP_LOAD_LIT, OP_STORE, OP_RET_IRQ, OP_RET_LIT, OP_RET_SUB,
        OP_ROT_L, OP_ROT_R, OP_SLEEP, OP_SUB_LIT, OP_SUB_FILE, OP_SWAP,
        OP_XOR_FILE, OP_XOR_LIT
    } cis_op_t;
endpackage

// *** cis_core.sv ***
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module cis_core (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [cis_pkg::AW-1:0] reg_addr_in,
    input wire logic [cis_pkg::DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [cis_pkg::DW-1:0] reg_rdata_out,
    output logic [7:0] acc_out,
    output logic halted_out,
    output logic global_irq_enable_out
);
    import cis_pkg::*;

    cis_state_t state_ff;
    cis_state_t nxt_state;
    cis_op_t op;
    logic [7:0] acc_ff;
    logic [PCW-1:0] pc_ff;
    logic [SPW-1:0] sp_ff;
    logic [PCW-1:0] stack_mem [STACK_DEPTH];
    logic [7:0] file_mem [FILE_DEPTH];
    logic [FAW-1:0] faddr_ff;
    logic c_ff;
    logic nibble_carry_ff;
    logic z_ff;
    logic timeout_status_ff;
    logic powerdown_status_ff;
    logic global_irq_enable_ff;
    logic [7:0] watchdog_counter_ff;
    logic [7:0] presc_ff;
    logic wdog_tick;
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] nxt_rdata;
    logic exec;
    logic [13:0] instr;
    logic [7:0] lit;
    logic [FAW-1:0] fsel;
    logic dbit;
    logic [7:0] fval;
    logic [PCW-1:0] stack_top;
    logic [7:0] minuend;
    logic [8:0] diff9;
    logic [4:0] diff_lo;
    logic [7:0] res;
    logic wr_acc;
    logic wr_file;
    logic nxt_c;
    logic nxt_nibble_carry;
    logic nxt_z;
    logic [7:0] status_view;

    // Instruction fields taken straight from the issue write
    assign instr = reg_wdata_in[13:0];
    assign lit = reg_wdata_in[7:0];
    assign fsel = reg_wdata_in[FAW-1:0];
    assign dbit = reg_wdata_in[7];
    assign fval = file_mem[fsel];
    assign stack_top = stack_mem[sp_ff - 3'h1];
    // Issue writes while stalled or halted are dropped
    assign exec = reg_wr_in && (reg_addr_in == REG_INSTR)
                  && (state_ff == ST_RUN);

    // Opcode decode, anything unknown runs as a no-op
    always_comb begin
        op = OP_NOP;
        if (instr[13:10] == OPC_LOAD_LIT) begin
            op = OP_LOAD_LIT;
        end else if (instr[13:10] == OPC_RET_LIT) begin
            op = OP_RET_LIT;
        end else if (instr[13:9] == OPC_SUB_LIT) begin
            op = OP_SUB_LIT;
        end else if (instr[13:8] == OPC_XOR_LIT) begin
            op = OP_XOR_LIT;
        end else if (instr[13:8] == OPC_ROT_L) begin
            op = OP_ROT_L;
        end else if (instr[13:8] == OPC_ROT_R) begin
            op = OP_ROT_R;
        end else if (instr[13:8] == OPC_SUB_FILE) begin
            op = OP_SUB_FILE;
        end else if (instr[13:8] == OPC_SWAP) begin
            op = OP_SWAP;
        end else if (instr[13:8] == OPC_XOR_FILE) begin
            op = OP_XOR_FILE;
        end else if (instr[13:7] == OPC_STORE) begin
            op = OP_STORE;
        end else if (instr == OPC_RET_IRQ) begin
            op = OP_RET_IRQ;
        end else if (instr == OPC_RET_SUB) begin
            op = OP_RET_SUB;
        end else if (instr == OPC_SLEEP) begin
            op = OP_SLEEP;
        end
    end

    assign minuend = (op == OP_SUB_LIT) ? lit : fval;
    assign diff9 = {1'b0, minuend} + {1'b0, ~acc_ff} + 9'h001;
    assign diff_lo = {1'b0, minuend[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;

    // Result and flag selection per instruction
    always_comb begin
        res = fval;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        nxt_c = c_ff;
        nxt_nibble_carry = nibble_carry_ff;
        nxt_z = z_ff;
        unique case (op)
            OP_LOAD_LIT: begin
                res = lit;
                wr_acc = 1'b1;
            end
            OP_STORE: begin
                res = acc_ff;
                wr_file = 1'b1;
            end
            OP_RET_LIT: begin
                res = lit;
                wr_acc = 1'b1;
            end
            OP_ROT_L: begin
                res = {fval[6:0], c_ff};
                nxt_c = fval[7];
            end
            OP_ROT_R: begin
                res = {c_ff, fval[7:1]};
                nxt_c = fval[0];
            end
            OP_SUB_LIT: begin
                res = diff9[7:0];
                wr_acc = 1'b1;
                nxt_c = diff9[8];
                nxt_nibble_carry = diff_lo[4];
                nxt_z = (diff9[7:0] == 8'h00);
            end
            OP_SUB_FILE: begin
                res = diff9[7:0];
                nxt_c = diff9[8];
                nxt_nibble_carry = diff_lo[4];
                nxt_z = (diff9[7:0] == 8'h00);
            end
            OP_SWAP: begin
                res = {fval[3:0], fval[7:4]};
            end
            OP_XOR_FILE: begin
                res = acc_ff ^ fval;
                nxt_z = ((acc_ff ^ fval) == 8'h00);
            end
            OP_XOR_LIT: begin
                res = acc_ff ^ lit;
                wr_acc = 1'b1;
                nxt_z = ((acc_ff ^ lit) == 8'h00);
            end
            OP_NOP, OP_RET_IRQ, OP_RET_SUB, OP_SLEEP: begin
                res = fval;
            end
        endcase
        if (op inside {OP_ROT_L, OP_ROT_R, OP_SUB_FILE, OP_SWAP,
                       OP_XOR_FILE}) begin
            wr_acc = !dbit;
            wr_file = dbit;
        end
    end

    // Sequencer: two-cycle returns stall, sleep halts until woken
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (exec && (op inside {OP_RET_LIT, OP_RET_SUB,
                                        OP_RET_IRQ})) begin
                    nxt_state = ST_WAIT;
                end else if (exec && op == OP_SLEEP) begin
                    nxt_state = ST_HALTED;
                end
            end
            ST_WAIT: begin
                nxt_state = ST_RUN;
            end
            ST_HALTED: begin
                if (reg_wr_in && reg_addr_in == REG_WAKE) begin
                    nxt_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Accumulator: instruction result or direct software write
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            acc_ff <= RST_ACC;
        end else if (exec && wr_acc) begin
            acc_ff <= res;
        end else if (reg_wr_in && reg_addr_in == REG_ACC) begin
            acc_ff <= reg_wdata_in[7:0];
        end
    end

    // File memory has no reset, like any data RAM
    always_ff @(posedge sys_clk_in) begin
        if (exec && wr_file) begin
            file_mem[fsel] <= res;
        end else if (reg_wr_in && reg_addr_in == REG_FDATA) begin
            file_mem[faddr_ff] <= reg_wdata_in[7:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            faddr_ff <= '0;
        end else if (reg_wr_in && reg_addr_in == REG_FADDR) begin
            faddr_ff <= reg_wdata_in[FAW-1:0];
        end
    end

    // Arithmetic flags; a write to status loads them directly
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            c_ff <= 1'b0;
            nibble_carry_ff <= 1'b0;
            z_ff <= 1'b0;
        end else if (exec) begin
            c_ff <= nxt_c;
            nibble_carry_ff <= nxt_nibble_carry;
            z_ff <= nxt_z;
        end else if (reg_wr_in && reg_addr_in == REG_STATUS) begin
            c_ff <= reg_wdata_in[ST_C];
            nibble_carry_ff <= reg_wdata_in[ST_NCARRY];
            z_ff <= reg_wdata_in[ST_Z];
        end
    end

    // interrupt enable set on return from irq
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            global_irq_enable_ff <= RST_IRQEN;
        end else if (exec && op == OP_RET_IRQ) begin
            global_irq_enable_ff <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == REG_STATUS) begin
            global_irq_enable_ff <= reg_wdata_in[ST_IRQEN];
        end
    end

    // sleep sets the timeout bit and clears the power-down bit
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            timeout_status_ff <= RST_TIMEOUT;
            powerdown_status_ff <= RST_PWRDN;
        end else if (exec && op == OP_SLEEP) begin
            timeout_status_ff <= 1'b1;
            powerdown_status_ff <= 1'b0;
        end
    end

    // Prescaler gives one-cycle enable to the watchdog counter
    assign wdog_tick = (presc_ff == PRESC_MAX);

    always_ff @(posedge sys_clk_in) begin
        if (reset_in || (exec && op == OP_SLEEP)) begin
            presc_ff <= PRESC_CLEAR;
            watchdog_counter_ff <= WDOG_CLEAR;
        end else begin
            presc_ff <= presc_ff + 8'h01;
            if (wdog_tick) begin
                watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
            end
        end
    end

    // returns pop; stack wraps, no overflow flag
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sp_ff <= '0;
        end else if (exec && (op inside {OP_RET_LIT, OP_RET_SUB,
                                         OP_RET_IRQ})) begin
            sp_ff <= sp_ff - 3'h1;
        end else if (reg_wr_in && reg_addr_in == REG_STACK) begin
            sp_ff <= sp_ff + 3'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reg_wr_in && reg_addr_in == REG_STACK && !exec) begin
            stack_mem[sp_ff] <= reg_wdata_in[PCW-1:0];
        end
    end

    // program counter reloaded from stack top
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pc_ff <= RST_PC;
        end else if (exec && (op inside {OP_RET_LIT, OP_RET_SUB,
                                         OP_RET_IRQ})) begin
            pc_ff <= stack_top;
        end else if (exec) begin
            pc_ff <= pc_ff + 13'h0001;
        end else if (reg_wr_in && reg_addr_in == REG_PC) begin
            pc_ff <= reg_wdata_in[PCW-1:0];
        end
    end

    // Status view for software
    always_comb begin
        status_view = 8'h00;
        status_view[ST_C] = c_ff;
        status_view[ST_NCARRY] = nibble_carry_ff;
        status_view[ST_Z] = z_ff;
        status_view[ST_PWRDN] = powerdown_status_ff;
        status_view[ST_TIMEOUT] = timeout_status_ff;
        status_view[ST_IRQEN] = global_irq_enable_ff;
        status_view[ST_HALT] = (state_ff == ST_HALTED);
        status_view[ST_STALL] = (state_ff == ST_WAIT);
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 16'h0000;
        unique case (reg_addr_in)
            REG_ACC: nxt_rdata = {8'h00, acc_ff};
            REG_STATUS: nxt_rdata = {8'h00, status_view};
            REG_PC: nxt_rdata = {3'h0, pc_ff};
            REG_STACK: nxt_rdata = {3'h0, stack_top};
            REG_WDOG: nxt_rdata = {presc_ff, watchdog_counter_ff};
            REG_FADDR: nxt_rdata = {9'h000, faddr_ff};
            REG_FDATA: nxt_rdata = {8'h00, file_mem[faddr_ff]};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || !reg_rd_in) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign acc_out = acc_ff;
    assign halted_out = (state_ff == ST_HALTED);
    assign global_irq_enable_out = global_irq_enable_ff;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    AST_LOAD_LIT: assert property (exec && op == OP_LOAD_LIT |=>
        acc_ff == $past(lit) && $stable({c_ff, nibble_carry_ff, z_ff}))
        else $error("literal load wrong");
    AST_RET_IRQ: assert property (exec && op == OP_RET_IRQ |=>
        global_irq_enable_ff && pc_ff == $past(stack_top)
        && $stable({c_ff, nibble_carry_ff, z_ff}))
        else $error("irq return wrong");
    AST_STORE: assert property (exec && op == OP_STORE |=>
        file_mem[$past(fsel)] == $past(acc_ff) && $stable(z_ff))
        else $error("store wrong");
    AST_RET_LIT: assert property (exec && op == OP_RET_LIT |=>
        (acc_ff == $past(lit) && state_ff == ST_WAIT) ##1 state_ff == ST_RUN)
        else $error("literal return wrong");
    AST_ROT_L: assert property (exec && op == OP_ROT_L && !dbit |=>
        acc_ff == {$past(fval[6:0]), $past(c_ff)} && c_ff == $past(fval[7])
        && $stable(z_ff))
        else $error("rotate left wrong");
    AST_ROT_R: assert property (exec && op == OP_ROT_R && !dbit |=>
        acc_ff == {$past(c_ff), $past(fval[7:1])} && c_ff == $past(fval[0]))
        else $error("rotate right wrong");
    AST_SLEEP: assert property (exec && op == OP_SLEEP |=>
        watchdog_counter_ff == WDOG_CLEAR && timeout_status_ff
        && !powerdown_status_ff && halted_out)
        else $error("sleep wrong");
    AST_RET_SUB: assert property (exec && op == OP_RET_SUB |=>
        pc_ff == $past(stack_top) && sp_ff == $past(sp_ff) - 3'h1
        && state_ff == ST_WAIT ##1 state_ff == ST_RUN)
        else $error("subroutine return wrong");
    AST_SUB_LIT: assert property (exec && op == OP_SUB_LIT |=>
        acc_ff == $past(lit) - $past(acc_ff))
        else $error("literal subtract wrong");
    AST_SUB_FILE: assert property (exec && op == OP_SUB_FILE
        && !dbit |=> acc_ff == $past(fval) - $past(acc_ff))
        else $error("file subtract wrong");
    AST_SWAP: assert property (exec && op == OP_SWAP && !dbit |=>
        acc_ff == {$past(fval[3:0]), $past(fval[7:4])}
        && $stable({c_ff, nibble_carry_ff, z_ff}))
        else $error("nibble exchange wrong");
    AST_XOR_FILE: assert property (exec && op == OP_XOR_FILE
        && !dbit |=> acc_ff == ($past(acc_ff) ^ $past(fval))
        && $stable(c_ff))
        else $error("xor file wrong");
    AST_XOR_LIT: assert property (exec && op == OP_XOR_LIT |=>
        acc_ff == ($past(acc_ff) ^ $past(lit)) && $stable(nibble_carry_ff))
        else $error("xor literal wrong");
    AST_DEST_FILE: assert property (exec && wr_file
        && op != OP_STORE |=> $stable(acc_ff)
        && file_mem[$past(fsel)] == $past(res))
        else $error("file destination wrong");
    AST_ZERO: assert property (exec
        && op inside {OP_SUB_LIT, OP_XOR_LIT} |=> z_ff == (acc_ff == 8'h00))
        else $error("zero flag wrong");
    AST_BORROW: assert property (exec && op == OP_SUB_LIT |=>
        c_ff == ($past(lit) >= $past(acc_ff)))
        else $error("borrow carry wrong");

    COV_SLEEP_WAKE: cover property (exec && op == OP_SLEEP ##[1:20]
        state_ff == ST_RUN);
    COV_RET_SUB: cover property (exec && op == OP_RET_SUB);
    COV_SUB_BORROW: cover property (exec && op == OP_SUB_FILE ##1 !c_ff);
    COV_XOR_ZERO: cover property (exec && op == OP_XOR_LIT ##1 z_ff);
endmodule

// *** cis_core_test.sv ***
`timescale 1ns/1ps
module cis_core_test;
    import cis_pkg::*;
    localparam logic [5:0] FOP [5] = '{OPC_SUB_FILE, OPC_XOR_FILE,
        OPC_SWAP, OPC_ROT_L, OPC_ROT_R};
    localparam logic [7:0] LK [4] = '{8'h00, 8'hFF, 8'h10, 8'h42};
    localparam logic [7:0] LW [4] = '{8'h01, 8'h00, 8'h01, 8'h42};
    logic sys_clk_in;
    logic reset_in;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [DW-1:0] rdata;
    logic [7:0] acc;
    logic halted;
    logic irq_en;
    logic [15:0] v;
    int n_mismatch;
    int n_checks;

    cis_core i_dut (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(wr),
        .reg_rd_in(rd),
        .reg_rdata_out(rdata),
        .acc_out(acc),
        .halted_out(halted),
        .global_irq_enable_out(irq_en)
    );

    // Free-running 50 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write strobe; gap before the next request
    task automatic bwr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic brd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Reference result {Z,DC,C,result}; flags not touched keep pre
    function automatic logic [10:0] calc(input int k, input logic [7:0] f,
        input logic [7:0] w, input logic [2:0] pre);
        logic [8:0] r;
        logic [2:0] fl;
        fl = pre;
        r = {1'b0, f};
        case (k)
            0: begin
                r = {1'b0, f} - {1'b0, w};
                fl[0] = ~r[8];
                fl[1] = (f[3:0] >= w[3:0]);
            end
            1: r[7:0] = f ^ w;
            2: r[7:0] = {f[3:0], f[7:4]};
            3: begin
                r[7:0] = {f[6:0], pre[0]};
                fl[0] = f[7];
            end
            default: begin
                r[7:0] = {pre[0], f[7:1]};
                fl[0] = f[0];
            end
        endcase
        if (k < 2) fl[2] = (r[7:0] == 8'h00);
        return {fl, r[7:0]};
    endfunction

    task automatic t_reset();
        brd(REG_STATUS, v);
        chk("status", v, 16'h0018);
        chk("acc", {8'h00, acc}, 16'h0000);
        chk("irq_en", {15'h0, irq_en}, 16'h0000);
        brd(8'h20, v);
        chk("unmapped", v, 16'h0000);
        brd(REG_INSTR, v);
        chk("instr_rd", v, 16'h0000);
    endtask

    task automatic t_lit();
        logic [10:0] e;
        for (int i = 0; i < 4; i++) begin
            e = calc(0, LK[i], LW[i], 3'b000);
            bwr(REG_ACC, {8'h00, LW[i]});
            bwr(REG_STATUS, 16'h0000);
            bwr(REG_INSTR, {2'b00, OPC_SUB_LIT, i[0], LK[i]});
            #1;
            chk("sub_acc", {8'h00, acc}, {8'h00, e[7:0]});
            brd(REG_STATUS, v);
            chk("sub_flags", {13'h0, v[2:0]}, {13'h0, e[10:8]});
        end
        bwr(REG_ACC, 16'h00A5);
        bwr(REG_STATUS, 16'h0003);
        bwr(REG_INSTR, {2'b00, OPC_XOR_LIT, 8'hA5});
        brd(REG_STATUS, v);
        chk("xorl_z", {13'h0, v[2:0]}, 16'h0007);
        bwr(REG_INSTR, {2'b00, OPC_XOR_LIT, 8'h5A});
        brd(REG_STATUS, v);
        chk("xorl_nz", {13'h0, v[2:0]}, 16'h0003);
        chk("xorl_acc", {8'h00, acc}, 16'h005A);
        bwr(REG_INSTR, {2'b00, OPC_LOAD_LIT, 2'b11, 8'hC3});
        #1;
        chk("load", {8'h00, acc}, 16'h00C3);
        bwr(REG_INSTR, {2'b00, OPC_STORE, 7'h7F});
        bwr(REG_FADDR, 16'h007F);
        brd(REG_FDATA, v);
        chk("store", v, 16'h00C3);
        brd(REG_STATUS, v);
        chk("mov_flags", {13'h0, v[2:0]}, 16'h0003);
    endtask

    task automatic t_file_ops();
        logic [10:0] e;
        logic [7:0] f;
        logic [2:0] p;
        for (int k = 0; k < 5; k++)
            for (int d = 0; d < 2; d++)
                for (int s = 0; s < 2; s++) begin
                    f = s ? 8'h3C : 8'h96;
                    p = s ? 3'b010 : 3'b101;
                    e = calc(k, f, 8'h3C, p);
                    bwr(REG_FADDR, {9'h0, 7'h7F - k[6:0]});
                    bwr(REG_FDATA, {8'h00, f});
                    bwr(REG_ACC, 16'h003C);
                    bwr(REG_STATUS, {13'h0, p});
                    bwr(REG_INSTR, {2'b00, FOP[k], d[0], 7'h7F - k[6:0]});
                    brd(REG_ACC, v);
                    chk("acc", v, {8'h00, d[0] ? 8'h3C : e[7:0]});
                    brd(REG_FDATA, v);
                    chk("file", v, {8'h00, d[0] ? e[7:0] : f});
                    brd(REG_STATUS, v);
                    chk("flags", {13'h0, v[2:0]}, {13'h0, e[10:8]});
                end
    endtask

    task automatic t_returns();
        bwr(REG_STACK, 16'h0123);
        bwr(REG_STACK, 16'h0456);
        bwr(REG_STATUS, 16'h0005);
        // two cycles: back-to-back issue is refused
        @(posedge sys_clk_in);
        addr <= REG_INSTR;
        wdata <= {2'b00, OPC_RET_LIT, 2'b00, 8'h5A};
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wdata <= {2'b00, OPC_LOAD_LIT, 2'b00, 8'h99};
        @(posedge sys_clk_in);
        wr <= 1'b0;
        #1;
        chk("retl_acc", {8'h00, acc}, 16'h005A);
        brd(REG_PC, v);
        chk("retl_pc", v, 16'h0456);
        bwr(REG_INSTR, {2'b00, OPC_RET_IRQ});
        brd(REG_PC, v);
        chk("reti_pc", v, 16'h0123);
        chk("reti_en", {15'h0, irq_en}, 16'h0001);
        brd(REG_STATUS, v);
        chk("reti_st", {10'h0, v[5:0]}, 16'h003D);
        bwr(REG_STACK, 16'h0789);
        bwr(REG_INSTR, {2'b00, OPC_RET_SUB});
        brd(REG_PC, v);
        chk("ret_pc", v, 16'h0789);
        brd(REG_STATUS, v);
        chk("ret_st", {13'h0, v[2:0]}, 16'h0005);
    endtask

    task automatic t_sleep();
        logic [7:0] a0;
        // sleep clears watchdog, sets status, halts
        repeat (300) @(posedge sys_clk_in);
        bwr(REG_INSTR, {2'b00, OPC_SLEEP});
        #1;
        chk("halted", {15'h0, halted}, 16'h0001);
        brd(REG_WDOG, v);
        chk("wdog", {8'h00, v[7:0]}, 16'h0000);
        chk("presc", {15'h0, v[15:8] < 8'h04}, 16'h0001);
        brd(REG_STATUS, v);
        chk("sleep_st", {14'h0, v[4:3]}, 16'h0002);
        a0 = acc;
        bwr(REG_INSTR, {2'b00, OPC_LOAD_LIT, 2'b00, 8'h77});
        #1;
        chk("halt_acc", {8'h00, acc}, {8'h00, a0});
        bwr(REG_WAKE, 16'h0001);
        #1;
        chk("woke", {15'h0, halted}, 16'h0000);
        bwr(REG_INSTR, {2'b00, OPC_LOAD_LIT, 2'b00, 8'h77});
        #1;
        chk("wake_acc", {8'h00, acc}, 16'h0077);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence after a five-cycle reset
    initial begin
        reset_in = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (5) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_lit();
        t_file_ops();
        t_returns();
        t_sleep();
        give_verdict();
    end

    // Watchdog well past the expected run of about 720 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_mismatch++;
        give_verdict();
    end
endmodule
